/* include/cio_pkg.sv */
// Purpose: Shared constants and types for the camera I/O line control block
// Assumes: 20 MHz hclk, AHB-Lite register access, 32-bit words
// Notes: Offsets are byte addresses of aligned words
package cio_pkg;

	// Line counts
	localparam int NUM_IN = 4;
	localparam int NUM_OUT = 2;

	// Register byte offsets
	localparam logic [7:0] OFS_OUT0_CFG = 8'h00;
	localparam logic [7:0] OFS_OUT1_CFG = 8'h04;
	localparam logic [7:0] OFS_IN_CFG = 8'h08;
	localparam logic [7:0] OFS_GLITCH = 8'h0C;
	localparam logic [7:0] OFS_STATUS = 8'h10;

	// Output config field positions
	localparam int SEL_LSB = 0;
	localparam int SEL_W = 4;
	localparam int FLIP_BIT = 8;
	localparam int HOST_BIT = 12;
	localparam int DIR_BIT = 16;

	// Status field positions
	localparam int STAT_IN_LSB = 0;
	localparam int STAT_OUT_LSB = 8;
	localparam int STAT_OE_LSB = 16;

	// Reset values
	localparam logic [31:0] RST_OUT_CFG = 32'h0000_0000;
	localparam logic [NUM_IN-1:0] RST_IN_FLIP = 4'h0;
	localparam logic [15:0] RST_GLITCH_US = 16'h000A;

	// Timing
	localparam int CLK_PERIOD_NS = 50;
	localparam int NS_PER_US = 1000;
	localparam int CYC_PER_US = (NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PULSE_TIME_NS = 1000;
	localparam int PULSE_CYCLES = (PULSE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [4:0] SUB_LAST = 5'(CYC_PER_US - 1);
	localparam logic [4:0] PULSE_LOAD = 5'(PULSE_CYCLES);

	// Output drive sources
	typedef enum logic [3:0] {
		SRC_OFF = 4'h0,
		SRC_CAPTURE_BEGIN = 4'h1,
		SRC_CAPTURE_FINISH = 4'h2,
		SRC_BLUE_BEGIN = 4'h3,
		SRC_RED_BEGIN = 4'h4,
		SRC_GREEN_BEGIN = 4'h5,
		SRC_IR_BEGIN = 4'h6,
		SRC_BLUE_FINISH = 4'h7,
		SRC_RED_FINISH = 4'h8,
		SRC_GREEN_FINISH = 4'h9,
		SRC_IR_FINISH = 4'hA,
		SRC_ROW_ONE = 4'hB,
		SRC_ROW_TWO = 4'hC,
		SRC_ROW_THREE = 4'hD,
		SRC_HOST = 4'hE
	} cio_src_t;

endpackage

/* hdl/cio_line_ctrl.sv */
// Purpose: Input glitch filtering and output drive selection for camera I/O lines
// Assumes: Event inputs are one-cycle pulses on hclk, row levels are on hclk
// Notes: AHB-Lite slave with zero wait states, always OKAY
// Functional notes
// - An input change is accepted only after the new level has lasted the programmed filter time in microseconds.
// - Each output line has a selector choosing a level source, an event pulse source or a host-held value.
// - With the off source selected the line is not driven and its enable stays low.
// - The capture-begin pulse source emits one pulse per capture begin event.
// - The capture-finish pulse source emits one pulse per capture finish event.
// - Four exposure-begin pulse sources exist, one each for blue, red, green and infrared rows.
// - Four exposure-finish pulse sources exist, one each for blue, red, green and infrared rows.
// - The row one level source follows the whole exposure of row one, blue in forward scan.
// - The row two level source follows the whole exposure of row two, red in forward scan.
// - The row three level source follows the whole exposure of row three, green in forward scan.
// - Each input and output line has an optional polarity inversion bit.
// - The host source makes the output follow a software-written bit.
//
// Our own choices: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ns
`default_nettype none

module cio_line_ctrl
	import cio_pkg::*;
(
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Camera events and levels
	input wire logic capture_begin_event,
	input wire logic capture_finish_event,
	input wire logic [3:0] expose_begin_event,
	input wire logic [3:0] expose_finish_event,
	input wire logic [2:0] row_exposing,
	// Input line pins and filtered result
	input wire logic [NUM_IN-1:0] line_in_pin,
	output logic [NUM_IN-1:0] line_in_level,
	// Output line pins
	output logic [NUM_OUT-1:0] line_out_pin,
	output logic [NUM_OUT-1:0] line_out_oe
);

	// Field decoding shared by the mux and the checks
	function automatic cio_src_t src_of(input logic [31:0] cfg);
		src_of = cio_src_t'(cfg[SEL_LSB +: SEL_W]);
	endfunction

	function automatic logic pulse_src(input cio_src_t s);
		pulse_src = (s >= SRC_CAPTURE_BEGIN) && (s <= SRC_IR_FINISH);
	endfunction

	// Register state
	logic [31:0] out_cfg [NUM_OUT];
	logic [NUM_IN-1:0] in_flip;
	logic [15:0] glitch_us;
	logic [31:0] next_out_cfg [NUM_OUT];
	logic [NUM_IN-1:0] next_in_flip;
	logic [15:0] next_glitch_us;

	// Bus data-phase state
	logic wr_pend;
	logic [7:0] wr_addr;
	logic [31:0] next_hrdata;
	logic next_wr_pend;
	logic [7:0] next_wr_addr;
	logic addr_ok;

	// Input filter state
	logic [NUM_IN-1:0] sync1;
	logic [NUM_IN-1:0] sync2;
	logic [NUM_IN-1:0] sync3;
	logic [NUM_IN-1:0] filt;
	logic [4:0] sub_cnt [NUM_IN];
	logic [15:0] us_cnt [NUM_IN];
	logic [NUM_IN-1:0] next_filt;
	logic [4:0] next_sub_cnt [NUM_IN];
	logic [15:0] next_us_cnt [NUM_IN];

	// Output state
	logic [4:0] pulse_cnt [NUM_OUT];
	logic [4:0] next_pulse_cnt [NUM_OUT];
	logic [NUM_OUT-1:0] next_line_out;
	logic [NUM_OUT-1:0] next_line_oe;
	logic [NUM_OUT-1:0] trig;

	// Zero wait state, always OKAY
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign addr_ok = hsel && htrans[1] && hready;

	// Bus decode and register writes
	always_comb begin
		next_out_cfg = out_cfg;
		next_in_flip = in_flip;
		next_glitch_us = glitch_us;
		next_wr_pend = addr_ok && hwrite;
		next_wr_addr = haddr[7:0];
		next_hrdata = hrdata;
		if (wr_pend) begin
			unique case (wr_addr)
				OFS_OUT0_CFG: next_out_cfg[0] = hwdata;
				OFS_OUT1_CFG: next_out_cfg[1] = hwdata;
				OFS_IN_CFG: next_in_flip = hwdata[NUM_IN-1:0];
				OFS_GLITCH: next_glitch_us = hwdata[15:0];
				default: ;
			endcase
		end
		if (addr_ok && !hwrite) begin
			next_hrdata = 32'h0000_0000;
			unique case (haddr[7:0])
				OFS_OUT0_CFG: next_hrdata = out_cfg[0];
				OFS_OUT1_CFG: next_hrdata = out_cfg[1];
				OFS_IN_CFG: next_hrdata[NUM_IN-1:0] = in_flip;
				OFS_GLITCH: next_hrdata[15:0] = glitch_us;
				OFS_STATUS: begin
					next_hrdata[STAT_IN_LSB +: NUM_IN] = line_in_level;
					next_hrdata[STAT_OUT_LSB +: NUM_OUT] = line_out_pin;
					next_hrdata[STAT_OE_LSB +: NUM_OUT] = line_out_oe;
				end
				default: ;
			endcase
		end
	end

	// Bus registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			out_cfg[0] <= RST_OUT_CFG;
			out_cfg[1] <= RST_OUT_CFG;
			in_flip <= RST_IN_FLIP;
			glitch_us <= RST_GLITCH_US;
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
			hrdata <= 32'h0000_0000;
		end else begin
			out_cfg <= next_out_cfg;
			in_flip <= next_in_flip;
			glitch_us <= next_glitch_us;
			wr_pend <= next_wr_pend;
			wr_addr <= next_wr_addr;
			hrdata <= next_hrdata;
		end
	end

	// Glitch filter: count whole microseconds of a steady new level
	always_comb begin
		next_filt = filt;
		next_sub_cnt = sub_cnt;
		next_us_cnt = us_cnt;
		for (int i = 0; i < NUM_IN; i++) begin
			if (sync3[i] != sync2[i] || sync3[i] == filt[i]) begin
				next_sub_cnt[i] = 5'h00;
				next_us_cnt[i] = 16'h0000;
			end else if (us_cnt[i] >= glitch_us) begin
				next_filt[i] = sync3[i];
				next_sub_cnt[i] = 5'h00;
				next_us_cnt[i] = 16'h0000;
			end else if (sub_cnt[i] == SUB_LAST) begin
				next_sub_cnt[i] = 5'h00;
				next_us_cnt[i] = us_cnt[i] + 16'h0001;
			end else begin
				next_sub_cnt[i] = sub_cnt[i] + 5'h01;
			end
		end
	end

	// Pin synchroniser and filter registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync1 <= '0;
			sync2 <= '0;
			sync3 <= '0;
			filt <= '0;
			line_in_level <= RST_IN_FLIP;
			for (int i = 0; i < NUM_IN; i++) begin
				sub_cnt[i] <= 5'h00;
				us_cnt[i] <= 16'h0000;
			end
		end else begin
			sync1 <= line_in_pin;
			sync2 <= sync1;
			sync3 <= sync2;
			filt <= next_filt;
			line_in_level <= next_filt ^ next_in_flip;
			sub_cnt <= next_sub_cnt;
			us_cnt <= next_us_cnt;
		end
	end

	// Source selection, pulse stretching and drive
	always_comb begin
		next_pulse_cnt = pulse_cnt;
		next_line_out = '0;
		next_line_oe = '0;
		trig = '0;
		for (int o = 0; o < NUM_OUT; o++) begin
			logic lvl;
			lvl = 1'b0;
			unique case (src_of(out_cfg[o]))
				SRC_CAPTURE_BEGIN: trig[o] = capture_begin_event;
				SRC_CAPTURE_FINISH: trig[o] = capture_finish_event;
				SRC_BLUE_BEGIN: trig[o] = expose_begin_event[0];
				SRC_RED_BEGIN: trig[o] = expose_begin_event[1];
				SRC_GREEN_BEGIN: trig[o] = expose_begin_event[2];
				SRC_IR_BEGIN: trig[o] = expose_begin_event[3];
				SRC_BLUE_FINISH: trig[o] = expose_finish_event[0];
				SRC_RED_FINISH: trig[o] = expose_finish_event[1];
				SRC_GREEN_FINISH: trig[o] = expose_finish_event[2];
				SRC_IR_FINISH: trig[o] = expose_finish_event[3];
				SRC_ROW_ONE: lvl = row_exposing[0];
				SRC_ROW_TWO: lvl = row_exposing[1];
				SRC_ROW_THREE: lvl = row_exposing[2];
				SRC_HOST: lvl = out_cfg[o][HOST_BIT];
				default: lvl = 1'b0;
			endcase
			// Fixed-width pulse, restarted by a new event
			if (!pulse_src(src_of(out_cfg[o])) || !out_cfg[o][DIR_BIT]) begin
				next_pulse_cnt[o] = 5'h00;
			end else if (trig[o]) begin
				next_pulse_cnt[o] = PULSE_LOAD;
			end else if (pulse_cnt[o] != 5'h00) begin
				next_pulse_cnt[o] = pulse_cnt[o] - 5'h01;
			end
			if (pulse_src(src_of(out_cfg[o]))) begin
				lvl = (next_pulse_cnt[o] != 5'h00);
			end
			next_line_oe[o] = out_cfg[o][DIR_BIT] && (src_of(out_cfg[o]) != SRC_OFF);
			next_line_out[o] = next_line_oe[o] && (lvl ^ out_cfg[o][FLIP_BIT]);
		end
	end

	// Output registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pulse_cnt[0] <= 5'h00;
			pulse_cnt[1] <= 5'h00;
			line_out_pin <= '0;
			line_out_oe <= '0;
		end else begin
			pulse_cnt <= next_pulse_cnt;
			line_out_pin <= next_line_out;
			line_out_oe <= next_line_oe;
		end
	end

	// Checks on output 0 and input 0, plus the off check on output 1
	wire cio_src_t sel0 = src_of(out_cfg[0]);
	wire logic dir0 = out_cfg[0][DIR_BIT];
	wire logic flip0 = out_cfg[0][FLIP_BIT];

	off_no_drive_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(sel0 == SRC_OFF) |=> !line_out_oe[0])
		else $error("line driven while source is off");

	dir_gates_a: assert property (@(posedge hclk) disable iff (!hresetn)
		!dir0 |=> !line_out_oe[0] && !line_out_pin[0])
		else $error("line driven while direction is input");

	host_level_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(sel0 == SRC_HOST && dir0) |=> line_out_pin[0] == ($past(out_cfg[0][HOST_BIT]) ^ $past(flip0)))
		else $error("host level not driven");

	row_one_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(sel0 == SRC_ROW_ONE && dir0) |=> line_out_pin[0] == ($past(row_exposing[0]) ^ $past(flip0)))
		else $error("row one level not followed");

	row_two_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(sel0 == SRC_ROW_TWO && dir0) |=> line_out_pin[0] == ($past(row_exposing[1]) ^ $past(flip0)))
		else $error("row two level not followed");

	row_three_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(sel0 == SRC_ROW_THREE && dir0) |=> line_out_pin[0] == ($past(row_exposing[2]) ^ $past(flip0)))
		else $error("row three level not followed");

	begin_pulse_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(sel0 == SRC_CAPTURE_BEGIN && dir0 && capture_begin_event && $stable(out_cfg[0]))
		|=> (line_out_pin[0] != $past(flip0)) && pulse_cnt[0] == PULSE_LOAD)
		else $error("capture begin pulse missing");

	finish_pulse_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(sel0 == SRC_CAPTURE_FINISH && dir0 && capture_finish_event)
		|=> pulse_cnt[0] == PULSE_LOAD)
		else $error("capture finish pulse missing");

	expose_begin_a: assert property (@(posedge hclk) disable iff (!hresetn)
		dir0 && ((sel0 == SRC_BLUE_BEGIN && expose_begin_event[0])
		|| (sel0 == SRC_RED_BEGIN && expose_begin_event[1])
		|| (sel0 == SRC_GREEN_BEGIN && expose_begin_event[2])
		|| (sel0 == SRC_IR_BEGIN && expose_begin_event[3]))
		|=> pulse_cnt[0] == PULSE_LOAD && line_out_pin[0] != $past(flip0))
		else $error("exposure begin pulse missing");

	expose_finish_a: assert property (@(posedge hclk) disable iff (!hresetn)
		dir0 && ((sel0 == SRC_BLUE_FINISH && expose_finish_event[0])
		|| (sel0 == SRC_RED_FINISH && expose_finish_event[1])
		|| (sel0 == SRC_GREEN_FINISH && expose_finish_event[2])
		|| (sel0 == SRC_IR_FINISH && expose_finish_event[3]))
		|=> pulse_cnt[0] == PULSE_LOAD && line_out_pin[0] != $past(flip0))
		else $error("exposure finish pulse missing");

	pulse_width_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(pulse_cnt[0] == PULSE_LOAD && pulse_src(sel0) && dir0 && !trig[0]) |=> pulse_cnt[0] == PULSE_LOAD - 5'h01)
		else $error("pulse width count wrong");

	filter_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(filt[0] != $past(filt[0])) |-> $past(us_cnt[0] >= glitch_us) && $past(sync3[0] == sync2[0]))
		else $error("input accepted before filter time");

	filter_restart_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(sync3[0] == filt[0]) |=> us_cnt[0] == 16'h0000 && sub_cnt[0] == 5'h00)
		else $error("filter timer not restarted");

	pulse_end_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(pulse_cnt[0] == 5'h01 && pulse_src(sel0) && dir0 && !trig[0]) |=> pulse_cnt[0] == 5'h00 && line_out_pin[0] == $past(flip0))
		else $error("pulse did not end");

	out1_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(src_of(out_cfg[1]) == SRC_OFF) |=> !line_out_oe[1] && !line_out_pin[1])
		else $error("line one driven while source is off");

	// Main scenarios
	host_cover_c: cover property (@(posedge hclk) disable iff (!hresetn)
		sel0 == SRC_HOST && dir0 ##1 line_out_oe[0]);
	pulse_cover_c: cover property (@(posedge hclk) disable iff (!hresetn)
		pulse_cnt[0] == PULSE_LOAD ##[1:40] pulse_cnt[0] == 5'h00);
	filter_cover_c: cover property (@(posedge hclk) disable iff (!hresetn)
		$rose(filt[0]));
	expose_cover_c: cover property (@(posedge hclk) disable iff (!hresetn)
		sel0 == SRC_IR_FINISH && dir0 && expose_finish_event[3]);
	retrigger_cover_c: cover property (@(posedge hclk) disable iff (!hresetn)
		pulse_cnt[0] != 5'h00 && pulse_cnt[0] != PULSE_LOAD ##1 pulse_cnt[0] == PULSE_LOAD);

endmodule // cio_line_ctrl

`default_nettype wire

/* verification/cio_line_equip.sv */
// Purpose: Machine equipment model on the camera I/O lines
// Assumes: Pins change just after rising hclk edges
// Notes: A released output line reads low through a pull-down
`timescale 1ns/1ns
`default_nettype none

module cio_line_equip
	import cio_pkg::*;
(
	// Clock
	input wire logic hclk,
	// Lines from the camera
	input wire logic [NUM_OUT-1:0] line_out_pin,
	input wire logic [NUM_OUT-1:0] line_out_oe,
	output logic [NUM_OUT-1:0] seen_level,
	// Lines into the camera
	output logic [NUM_IN-1:0] line_in_pin
);
	// Pull-down wins while the camera is not driving
	assign seen_level = line_out_pin & line_out_oe;
	// Quiet lines at start
	initial line_in_pin = '0;

	// Hold a line at a level
	task automatic set_line(input int i, input logic v);
		line_in_pin[i] <= v;
	endtask

	// Contact bounce of n cycles, then back
	task automatic bounce(input int i, input int n);
		@(posedge hclk);
		line_in_pin[i] <= ~line_in_pin[i];
		repeat (n) @(posedge hclk);
		line_in_pin[i] <= ~line_in_pin[i];
	endtask
endmodule // cio_line_equip

`default_nettype wire

/* verification/cio_line_ctrl_tb.sv */
// Purpose: Self-checking bench for the camera I/O line control block
// Assumes: Zero wait state slave on a 20 MHz hclk
// Notes: Filter time is cut to 1 us for the input tests
`timescale 1ns/1ns
`default_nettype none

module cio_line_ctrl_tb
	import cio_pkg::*;
;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
	logic [1:0] htrans = '0;
	logic [31:0] haddr = '0, hwdata = '0;
	logic capture_begin_event = 0, capture_finish_event = 0;
	logic [3:0] expose_begin_event = '0, expose_finish_event = '0;
	logic [2:0] row_exposing = '0;
	wire logic hreadyout, hresp;
	wire logic [31:0] hrdata;
	wire logic [NUM_IN-1:0] line_in_pin, line_in_level;
	wire logic [NUM_OUT-1:0] line_out_pin, line_out_oe, seen_level;
	int err_count = 0;
	int tests_run = 0;
	logic [31:0] rng = 32'hddc2_d427;
	typedef struct packed {int src; logic [31:0] exp;} cio_note_t;
	cio_note_t notes[$];

	cio_line_ctrl cio_line_ctrl_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .capture_begin_event(capture_begin_event),
		.capture_finish_event(capture_finish_event), .expose_begin_event(expose_begin_event),
		.expose_finish_event(expose_finish_event), .row_exposing(row_exposing),
		.line_in_pin(line_in_pin), .line_in_level(line_in_level), .line_out_pin(line_out_pin),
		.line_out_oe(line_out_oe));
	cio_line_equip cio_line_equip_inst (.hclk(hclk), .line_out_pin(line_out_pin),
		.line_out_oe(line_out_oe), .seen_level(seen_level), .line_in_pin(line_in_pin));

	// Clock
	always #25 hclk = ~hclk;

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	// Expected {line1 oe, line0 seen, line0 oe, line0 pin}
	function automatic logic [31:0] out_exp(input logic oe, input logic v);
		return {28'h0, 1'b0, v & oe, oe, v & oe};
	endfunction

	task automatic note(input int src, input logic [31:0] exp);
		notes.push_back('{src, exp});
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask

	task automatic end_sim();
		$display("counts: %0d compares, %0d mismatches", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
		hsel <= 1;
		htrans <= 2'h2;
		hwrite <= 1;
		haddr <= 32'(a);
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
	endtask

	task automatic bus_read(input logic [7:0] a, input logic [31:0] exp);
		hsel <= 1;
		htrans <= 2'h2;
		hwrite <= 0;
		haddr <= 32'(a);
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 0;
		htrans <= 2'h0;
		note(0, exp);
		do @(posedge hclk); while (hreadyout !== 1'b1);
	endtask

	// Source k event: 1,2 capture, 3..6 exposure begin, 7..10 exposure finish
	task automatic fire(input int k);
		{expose_finish_event, expose_begin_event, capture_finish_event, capture_begin_event} <= 10'(1) << (k - 1);
		@(posedge hclk);
		{expose_finish_event, expose_begin_event, capture_finish_event, capture_begin_event} <= '0;
	endtask

	// Compare settled outputs against every queued note, oldest first
	always @(negedge hclk) begin
		cio_note_t n;
		while (notes.size() > 0) begin
			n = notes.pop_front();
			case (n.src)
				0: begin
					check(hrdata, n.exp);
					check(32'(hresp), 32'h0000_0000);
				end
				1: check(32'({line_out_oe[1], seen_level[0], line_out_oe[0], line_out_pin[0]}), n.exp);
				default: check(32'(line_in_level), n.exp);
			endcase
		end
	end

	// Watchdog
	initial begin
		repeat (20000) @(posedge hclk);
		err_count++;
		end_sim();
	end

	// Main sequence
	initial begin
		repeat (5) @(posedge hclk);
		hresetn <= 1;
		@(posedge hclk);
		bus_read(OFS_OUT0_CFG, RST_OUT_CFG);
		bus_read(OFS_IN_CFG, 32'h0000_0000);
		bus_read(OFS_GLITCH, 32'(RST_GLITCH_US));
		bus_read(OFS_STATUS, 32'h0000_0000);
		bus_write(8'h14, rng);
		bus_read(8'h14, 32'h0000_0000);
		bus_write(OFS_GLITCH, 32'h0000_0001);
		bus_read(OFS_GLITCH, 32'h0000_0001);
		$display("test registers done");
		for (int s = 1; s <= 10; s++) begin
			bus_write(OFS_OUT0_CFG, 32'h0001_0000 | 32'(s));
			fire(s % 10 + 1);
			note(1, out_exp(1, 0));
			@(posedge hclk);
			fire(s);
			note(1, out_exp(1, 1));
			repeat (19) @(posedge hclk);
			note(1, out_exp(1, 1));
			@(posedge hclk);
			note(1, out_exp(1, 0));
		end
		$display("test pulses done");
		for (int s = 11; s <= 14; s++) begin
			rng = xs(rng);
			bus_write(OFS_OUT0_CFG, 32'h0001_0000 | (rng & 32'h0000_1100) | 32'(s));
			row_exposing <= rng[2:0];
			repeat (2) @(posedge hclk);
			note(1, out_exp(1, (s == 14 ? rng[12] : rng[s - 11]) ^ rng[8]));
			row_exposing <= ~rng[2:0];
			repeat (2) @(posedge hclk);
			note(1, out_exp(1, (s == 14 ? rng[12] : ~rng[s - 11]) ^ rng[8]));
		end
		bus_write(OFS_OUT0_CFG, 32'h0000_100E);
		@(posedge hclk);
		note(1, out_exp(0, 0));
		bus_write(OFS_OUT0_CFG, 32'h0001_0100);
		@(posedge hclk);
		note(1, out_exp(0, 0));
		$display("test levels done");
		cio_line_equip_inst.bounce(0, 12);
		repeat (4) @(posedge hclk);
		cio_line_equip_inst.bounce(0, 12);
		repeat (30) @(posedge hclk);
		note(2, 32'h0000_0000);
		cio_line_equip_inst.set_line(0, 1);
		repeat (20) @(posedge hclk);
		note(2, 32'h0000_0000);
		repeat (20) @(posedge hclk);
		note(2, 32'h0000_0001);
		bus_write(OFS_IN_CFG, 32'h0000_0001);
		@(posedge hclk);
		note(2, 32'h0000_0000);
		bus_write(OFS_OUT1_CFG, 32'h0001_010F);
		bus_read(OFS_OUT1_CFG, 32'h0001_010F);
		bus_write(OFS_OUT0_CFG, 32'h0001_100E);
		@(posedge hclk);
		bus_read(OFS_STATUS, 32'h0003_0300);
		$display("test inputs done");
		repeat (2) @(posedge hclk);
		end_sim();
	end
endmodule // cio_line_ctrl_tb

`default_nettype wire
